// File: swm_pkg.sv
// Constants for the serial wire mode and clock select block
// What this block does
// - Wire mode 00 disables outputs and hold; start detector stays on
// - Inputs always feed shift register and counter
// - Two-wire mode: start condition sets start flag
// - Off/three-wire: clock pin edge sets start flag with external source and strobe 0
// - Three-wire: shift output replaces port bit one
// - Three-wire: data in and clock pins stay normal
// - Two-wire: open-collector drivers enabled by direction bits
// - Two-wire: data low when shift out or port0 zero
// - Two-wire: clock low when port2 zero or hold
// - Start hold keeps clock low until flag cleared
// - Two-wire: pull-ups off on data and clock pins
// - Mode 11 also holds clock after counter overflow
// - Source field clocks both; 00 with strobe 0 none
// - External clock: output changes on opposite edge
// - Strobe or timer clock: output latch transparent
// - Source 01: timer overflow steps register and counter
// - External: shift on chosen edge, count both edges
// - External with select: counter steps on toggle strobe
// - Source 00: strobe write shifts and counts immediately
// - Strobe shift takes input sampled previous cycle
// - Clock strobe bit always reads zero
// - Overflow flag set on 15 to 0, write-one clears
// - Toggle strobe inverts port bit two always
// - External clock: latch open first half cycle only
package swm_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 2;
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_DATA = 2'h2;
    localparam logic [1:0] ADDR_PORT = 2'h3;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_WM_LO = 4;
    localparam int CTRL_CS_LO = 2;
    localparam int CTRL_STROBE = 1;
    localparam int CTRL_TOGGLE = 0;
    localparam int STAT_SIF = 7;
    localparam int STAT_OIF = 6;
    localparam int PORT_DIR_LO = 4;

    // ****************************************
    // Reset values and counter maximum
    // ****************************************
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam logic [2:0] PORT_RST = 3'h0;

    // ****************************************
    // Modes
    // ****************************************
    typedef enum logic [1:0] {
        SWM_WM_OFF = 2'b00,
        SWM_WM_THREE = 2'b01,
        SWM_WM_TWO = 2'b10,
        SWM_WM_TWO_HOLD = 2'b11
    } swm_wm_t;

    typedef enum logic [1:0] {
        SWM_CS_SOFT = 2'b00,
        SWM_CS_TIMER = 2'b01,
        SWM_CS_EXT_RISE = 2'b10,
        SWM_CS_EXT_FALL = 2'b11
    } swm_cs_t;

endpackage : swm_pkg

// File: swm_top.sv
// Wire mode and clock select logic of the universal serial interface
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module swm_top
    import swm_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Timer overflow pulse, same clock
    input wire logic i_timer0_ovf,
    // Pin inputs, asynchronous
    input wire logic i_pin0_in,
    input wire logic i_pin2_in,
    // Pin 0: data in / two-wire data
    output logic o_pin0_out,
    output logic o_pin0_oe,
    output logic o_pin0_pullup,
    // Pin 1: three-wire data out
    output logic o_pin1_out,
    output logic o_pin1_oe,
    output logic o_pin1_pullup,
    // Pin 2: serial clock
    output logic o_pin2_out,
    output logic o_pin2_oe,
    output logic o_pin2_pullup
);

    // ****************************************
    // Declarations
    // ****************************************
    swm_wm_t wm_q; // Wire mode
    swm_cs_t cs_q; // Clock source
    logic sel_q; // Stored strobe select, reads as zero
    logic sif_q; // Start condition flag
    logic oif_q; // Counter overflow flag
    logic [3:0] cnt_q; // Edge counter
    logic [7:0] shreg_q; // Shift register
    logic latch_q; // Output latch after bit 7
    logic [2:0] port_q; // Port output bits
    logic [2:0] dir_q; // Direction bits
    logic [1:0] sda_sync_q; // Data pin synchroniser
    logic [1:0] scl_sync_q; // Clock pin synchroniser
    logic sda_d1_q; // Delayed data level for edges
    logic scl_d1_q; // Delayed clock level for edges
    logic wr_ctrl, wr_stat, wr_data, wr_port;
    logic scl_rise, scl_fall, sda_fall;
    logic shift_pulse, count_pulse, start_event;
    logic two_wire, latch_open, hold_scl;
    logic [7:0] rdata_d;
    logic [2:0] pin_out_d, pin_oe_d, pin_pu_d;

    // ****************************************
    // Address decode
    // ****************************************
    // Decode one register write
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        hit = (a == b);
    endfunction : hit

    assign wr_ctrl = i_wr && hit(i_addr, ADDR_CTRL);
    assign wr_stat = i_wr && hit(i_addr, ADDR_STATUS);
    assign wr_data = i_wr && hit(i_addr, ADDR_DATA);
    assign wr_port = i_wr && hit(i_addr, ADDR_PORT);

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Two flops per pin, then one more stage for edge detection
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sda_sync_q <= 2'h3;
            scl_sync_q <= 2'h3;
            sda_d1_q <= 1'b1;
            scl_d1_q <= 1'b1;
        end
        else
        begin
            sda_sync_q <= {sda_sync_q[0], i_pin0_in};
            scl_sync_q <= {scl_sync_q[0], i_pin2_in};
            sda_d1_q <= sda_sync_q[1];
            scl_d1_q <= scl_sync_q[1];
        end
    end

    // Edges seen only from the second stage onward
    assign scl_rise = scl_sync_q[1] && !scl_d1_q;
    assign scl_fall = !scl_sync_q[1] && scl_d1_q;
    assign sda_fall = !sda_sync_q[1] && sda_d1_q;
    assign two_wire = wm_q[1];

    // ****************************************
    // Clock selection
    // ****************************************
    // Inputs feed the shifter whatever the wire mode
    always_comb
    begin
        shift_pulse = 1'b0;
        count_pulse = 1'b0;
        case (cs_q)
            SWM_CS_SOFT:
            begin
                shift_pulse = 1'b0;
            end
            SWM_CS_TIMER:
            begin
                shift_pulse = i_timer0_ovf;
                count_pulse = i_timer0_ovf;
            end
            SWM_CS_EXT_RISE, SWM_CS_EXT_FALL:
            begin
                // Low source bit picks the shifting edge
                shift_pulse = cs_q[0] ? scl_fall : scl_rise;
                // Counter takes both edges unless the toggle strobe clocks it
                count_pulse = sel_q ? (wr_ctrl && i_wdata[CTRL_TOGGLE])
                                    : (scl_rise || scl_fall);
            end
            default:
            begin
                shift_pulse = 1'b0;
            end
        endcase
        // Software strobe only counts when the written source is 00
        if (wr_ctrl && i_wdata[CTRL_STROBE] && (i_wdata[CTRL_CS_LO +: 2] == SWM_CS_SOFT))
        begin
            shift_pulse = 1'b1;
            count_pulse = 1'b1;
        end
    end

    // Start detection: bus start in two-wire, otherwise clock edges with external source and select clear
    assign start_event = two_wire ? (sda_fall && scl_sync_q[1])
                       : (cs_q[1] && !sel_q && (scl_rise || scl_fall));

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wm_q <= SWM_WM_OFF;
            cs_q <= SWM_CS_SOFT;
            sel_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            wm_q <= swm_wm_t'(i_wdata[CTRL_WM_LO +: 2]);
            cs_q <= swm_cs_t'(i_wdata[CTRL_CS_LO +: 2]);
            sel_q <= i_wdata[CTRL_STROBE];
        end
    end

    // ****************************************
    // Port bits
    // ****************************************
    // Toggle strobe flips port bit two regardless of direction
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            port_q <= PORT_RST;
            dir_q <= PORT_RST;
        end
        else if (wr_port)
        begin
            port_q <= i_wdata[2:0];
            dir_q <= i_wdata[PORT_DIR_LO +: 3];
        end
        else if (wr_ctrl && i_wdata[CTRL_TOGGLE])
        begin
            port_q[2] <= !port_q[2];
        end
    end

    // ****************************************
    // Shift register and output latch
    // ****************************************
    // A data write in the same cycle as a shift wins, no shift
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            shreg_q <= DATA_RST;
        end
        else if (wr_data)
        begin
            shreg_q <= i_wdata;
        end
        else if (shift_pulse)
        begin
            // Synchronised level was taken in the previous cycle
            shreg_q <= {shreg_q[6:0], sda_sync_q[1]};
        end
    end

    // Internal sources keep the latch open; external only in first half
    assign latch_open = !cs_q[1] || (cs_q[0] ? scl_sync_q[1] : !scl_sync_q[1]);

    // Holding bit 7 while closed moves output change to the opposite edge
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            latch_q <= 1'b0;
        end
        else if (latch_open)
        begin
            latch_q <= shreg_q[7];
        end
    end

    // ****************************************
    // Counter and flags
    // ****************************************
    // Counter write wins over a count in the same cycle
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cnt_q <= CNT_RST;
        end
        else if (wr_stat)
        begin
            cnt_q <= i_wdata[3:0];
        end
        else if (count_pulse)
        begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // Start flag set wins over a write-one clear; any status write blocks the overflow set
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sif_q <= 1'b0;
            oif_q <= 1'b0;
        end
        else
        begin
            // Bus start in two-wire; clock edges flag in wire modes 00 and 01
            if (start_event)
            begin
                sif_q <= 1'b1;
            end
            else if (wr_stat && i_wdata[STAT_SIF])
            begin
                sif_q <= 1'b0;
            end
            if (count_pulse && !wr_stat && cnt_q == CNT_MAX)
            begin
                oif_q <= 1'b1;
            end
            else if (wr_stat && i_wdata[STAT_OIF])
            begin
                oif_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    // Clock hold from start flag, and in mode 11 also from overflow
    assign hold_scl = sif_q || (wm_q == SWM_WM_TWO_HOLD && oif_q);

    always_comb
    begin
        // Ordinary port behaviour by default
        pin_out_d = port_q;
        pin_oe_d = dir_q;
        pin_pu_d = port_q & ~dir_q;
        case (wm_q)
            SWM_WM_OFF:
            begin
                pin_out_d = port_q;
            end
            SWM_WM_THREE:
            begin
                // Only the data out pin is taken over; others stay normal
                pin_out_d[1] = latch_q;
            end
            SWM_WM_TWO, SWM_WM_TWO_HOLD:
            begin
                // Open collector: drive low only, never high
                pin_out_d[0] = 1'b0;
                pin_out_d[2] = 1'b0;
                pin_oe_d[0] = dir_q[0] && (!latch_q || !port_q[0]);
                pin_oe_d[2] = dir_q[2] && (!port_q[2] || hold_scl);
                pin_pu_d[0] = 1'b0;
                pin_pu_d[2] = 1'b0;
            end
            default:
            begin
                pin_out_d = port_q;
            end
        endcase
    end

    // Register every pin output
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            {o_pin2_out, o_pin1_out, o_pin0_out} <= 3'h0;
            {o_pin2_oe, o_pin1_oe, o_pin0_oe} <= 3'h0;
            {o_pin2_pullup, o_pin1_pullup, o_pin0_pullup} <= 3'h0;
        end
        else
        begin
            {o_pin2_out, o_pin1_out, o_pin0_out} <= pin_out_d;
            {o_pin2_oe, o_pin1_oe, o_pin0_oe} <= pin_oe_d;
            {o_pin2_pullup, o_pin1_pullup, o_pin0_pullup} <= pin_pu_d;
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    // Strobe bits are not stored as readable state
    always_comb
    begin
        rdata_d = 8'h00;
        case (i_addr)
            ADDR_CTRL: rdata_d = {2'h0, wm_q, cs_q, 2'h0};
            ADDR_STATUS: rdata_d = {sif_q, oif_q, 2'h0, cnt_q};
            ADDR_DATA: rdata_d = shreg_q;
            ADDR_PORT: rdata_d = {1'b0, dir_q, 1'b0, port_q};
            default: rdata_d = 8'h00;
        endcase
    end

    // Data valid only in the cycle after the read strobe
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_rdata <= 8'h00;
        end
        else
        begin
            o_rdata <= i_rd ? rdata_d : 8'h00;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    property p_off_plain;
        (wm_q == SWM_WM_OFF) |=> (o_pin1_out == $past(port_q[1]) && o_pin0_oe == $past(dir_q[0]));
    endproperty
    a_off_plain: assert property (p_off_plain) else $error("mode 00 pins not plain");

    property p_two_start;
        (two_wire && start_event && !wr_ctrl) |=> sif_q;
    endproperty
    a_two_start: assert property (p_two_start) else $error("start not flagged");

    property p_edge_start;
        (!two_wire && cs_q[1] && !sel_q && (scl_rise || scl_fall) && !wr_ctrl)
            |=> sif_q;
    endproperty
    a_edge_start: assert property (p_edge_start) else $error("edge not flagged");

    property p_sda_low;
        (two_wire && dir_q[0] && !port_q[0]) |=> (o_pin0_oe && !o_pin0_out);
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("data line not pulled");

    property p_start_hold;
        (two_wire && sif_q && dir_q[2]) |=> o_pin2_oe;
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("clock not held");

    property p_ovf_hold;
        (wm_q == SWM_WM_TWO_HOLD && oif_q && dir_q[2]) |=> (o_pin2_oe && !o_pin2_out);
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow hold missing");

    property p_no_pullup;
        two_wire |=> (!o_pin0_pullup && !o_pin2_pullup);
    endproperty
    a_no_pullup: assert property (p_no_pullup) else $error("pull-up in two-wire");

    property p_sw_strobe;
        (wr_ctrl && i_wdata[CTRL_STROBE] && i_wdata[3:2] == 2'b00)
            |=> (cnt_q == $past(cnt_q) + 4'h1 && shreg_q[0] == $past(sda_sync_q[1]));
    endproperty
    a_sw_strobe: assert property (p_sw_strobe) else $error("strobe did not step");

    property p_strobe_reads_zero;
        (i_rd && i_addr == ADDR_CTRL) |=> (o_rdata[1:0] == 2'b00);
    endproperty
    a_strobe_reads_zero: assert property (p_strobe_reads_zero) else $error("strobe read");

    property p_overflow;
        (count_pulse && !wr_stat && cnt_q == CNT_MAX) |=> (oif_q && cnt_q == 4'h0);
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");

    property p_toggle;
        (wr_ctrl && i_wdata[CTRL_TOGGLE]) |=> (port_q[2] != $past(port_q[2]));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle failed");

endmodule : swm_top

`default_nettype wire

// File: swm_link_peer.sv
// Bus peer model: drives the serial clock and data lines, with pull-ups
`timescale 1ns/1ps
`default_nettype none

module swm_link_peer (
    // Device pin drivers
    input wire logic i_sda_out,
    input wire logic i_sda_oe,
    input wire logic i_scl_out,
    input wire logic i_scl_oe,
    // Resolved line levels
    output logic o_sda,
    output logic o_scl
);
    // Peer drive; a one means released to the pull-up
    logic scl_q = 1'b0;
    logic sda_q = 1'b1;

    // An enabled device driver can only pull a pulled-up line low
    assign o_sda = i_sda_oe ? (i_sda_out & sda_q) : sda_q;
    assign o_scl = i_scl_oe ? (i_scl_out & scl_q) : scl_q;

    // Set both lines at once; the clock then stands still
    task automatic set_lines(input logic c, input logic d);
        scl_q <= c;
        sda_q <= d;
    endtask : set_lines

    // Clock pulses at the 64 ns link rate, one data bit per pulse, MSB first
    // Data moves a quarter period after the trailing edge, so it is settled
    // at both edges and either sampling edge takes the intended bit
    task automatic pulses(input int n, input logic [7:0] bits, input logic idle);
        for (int i = n - 1; i >= 0; i--)
        begin
            #16 sda_q <= bits[i];
            #16 scl_q <= ~idle;
            #32 scl_q <= idle;
        end
    endtask : pulses
endmodule : swm_link_peer

`default_nettype wire

// File: serial_wire_mode_clock_select_tb_top.sv
// Self-checking bench for the wire mode and clock select block
`timescale 1ns/1ps
`default_nettype none

module serial_wire_mode_clock_select_tb_top;
    import swm_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic tmr = 1'b0;
    logic [7:0] rdata;
    logic p0o, p0e, p0u, p1o, p1e, p1u, p2o, p2e, p2u;
    wire logic sda;
    wire logic scl;
    int miscompares = 0;
    int samples_checked = 0;

    // 125 MHz system clock
    always #4 i_clk = ~i_clk;

    swm_top u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_timer0_ovf(tmr), .i_pin0_in(sda),
        .i_pin2_in(scl), .o_pin0_out(p0o), .o_pin0_oe(p0e), .o_pin0_pullup(p0u),
        .o_pin1_out(p1o), .o_pin1_oe(p1e), .o_pin1_pullup(p1u), .o_pin2_out(p2o),
        .o_pin2_oe(p2e), .o_pin2_pullup(p2u));

    swm_link_peer u_peer (.i_sda_out(p0o), .i_sda_oe(p0e), .i_scl_out(p2o),
        .i_scl_oe(p2e), .o_sda(sda), .o_scl(scl));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One-cycle write strobe
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] e, input string name,
        input logic [7:0] m = 8'hFF);
        @(posedge i_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        chk(name, {1'b0, e & m}, {1'b0, rdata & m});
    endtask : rd_reg

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc

    // One timer overflow pulse
    task automatic tick;
        @(posedge i_clk);
        tmr <= 1'b1;
        @(posedge i_clk);
        tmr <= 1'b0;
    endtask : tick

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rd_reg(ADDR_CTRL, 8'h00, "ctrl reset");
        rd_reg(ADDR_STATUS, 8'h00, "status reset");
        rd_reg(ADDR_DATA, DATA_RST, "data reset");
        chk("pins reset", 9'h000, {p0o, p0e, p0u, p1o, p1e, p1u, p2o, p2e, p2u});
    endtask : t_reset

    // Software strobe shifts the synchronised input; no strobe, no clock
    task automatic t_soft;
        u_peer.set_lines(1'b0, 1'b0);
        wr_reg(ADDR_STATUS, 8'hC0);
        wr_reg(ADDR_DATA, 8'h81);
        cyc(4);
        wr_reg(ADDR_CTRL, 8'h02);
        u_peer.set_lines(1'b0, 1'b1);
        cyc(4);
        wr_reg(ADDR_CTRL, 8'h02);
        wr_reg(ADDR_CTRL, 8'h00);
        tick();
        rd_reg(ADDR_DATA, 8'h05, "soft data");
        rd_reg(ADDR_STATUS, 8'h02, "soft count");
        rd_reg(ADDR_CTRL, 8'h00, "strobe bit");
    endtask : t_soft

    // Timer overflow clocks both, counter wraps and sets the flag
    task automatic t_timer;
        wr_reg(ADDR_DATA, 8'h01);
        wr_reg(ADDR_STATUS, 8'h0E);
        wr_reg(ADDR_CTRL, 8'h04);
        tick();
        tick();
        rd_reg(ADDR_DATA, 8'h07, "timer data");
        rd_reg(ADDR_STATUS, 8'h40, "overflow");
        wr_reg(ADDR_STATUS, 8'h40);
        rd_reg(ADDR_STATUS, 8'h00, "overflow clear");
    endtask : t_timer

    // External edges, outputs off and three-wire; then toggle-counted
    task automatic t_ext;
        for (int k = 0; k < 2; k++)
        begin
            wr_reg(ADDR_CTRL, k ? 8'h1C : 8'h08);
            wr_reg(ADDR_DATA, 8'h00);
            wr_reg(ADDR_STATUS, 8'hC0);
            u_peer.pulses(2, 8'h02, 1'b0);
            cyc(6);
            rd_reg(ADDR_DATA, 8'h02, "ext data");
            rd_reg(ADDR_STATUS, 8'h84, "ext status");
        end
        wr_reg(ADDR_CTRL, 8'h1A);
        wr_reg(ADDR_STATUS, 8'hC0);
        u_peer.pulses(2, 8'h03, 1'b0);
        cyc(6);
        wr_reg(ADDR_CTRL, 8'h1B);
        wr_reg(ADDR_CTRL, 8'h1B);
        rd_reg(ADDR_DATA, 8'h0B, "select data");
        rd_reg(ADDR_STATUS, 8'h02, "select count");
    endtask : t_ext

    // Data out pin ownership and the output latch
    task automatic t_three;
        wr_reg(ADDR_PORT, 8'h20);
        wr_reg(ADDR_DATA, 8'h80);
        wr_reg(ADDR_CTRL, 8'h00);
        cyc(3);
        chk("pin1 port", 9'h001, {7'h00, p1o, p1e});
        wr_reg(ADDR_CTRL, 8'h18);
        cyc(3);
        chk("pin1 shift", 9'h003, {7'h00, p1o, p1e});
        wr_reg(ADDR_DATA, 8'h40);
        cyc(3);
        chk("pin1 open", 9'h001, {7'h00, p1o, p1e});
        u_peer.set_lines(1'b1, 1'b1);
        cyc(6);
        chk("pin1 closed", 9'h001, {7'h00, p1o, p1e});
        u_peer.set_lines(1'b0, 1'b1);
        cyc(6);
        chk("pin1 after fall", 9'h003, {7'h00, p1o, p1e});
        wr_reg(ADDR_PORT, 8'h02);
        cyc(3);
        chk("pin1 pullup", 9'h001, {7'h00, p1e, p1u});
    endtask : t_three

    // Open-collector lines, start hold and overflow hold
    task automatic t_two;
        wr_reg(ADDR_CTRL, 8'h00);
        u_peer.set_lines(1'b1, 1'b1);
        wr_reg(ADDR_DATA, 8'hFF);
        wr_reg(ADDR_PORT, 8'h55);
        wr_reg(ADDR_CTRL, 8'h20);
        wr_reg(ADDR_STATUS, 8'hC0);
        cyc(3);
        chk("lines idle", 9'h003, {7'h00, scl, sda});
        chk("pullups", 9'h000, {7'h00, p0u, p2u});
        // Clock is pulled low first so that data moves are no start
        wr_reg(ADDR_CTRL, 8'h21);
        rd_reg(ADDR_PORT, 8'h51, "toggle");
        chk("scl port2", 9'h001, {7'h00, scl, sda});
        wr_reg(ADDR_PORT, 8'h50);
        cyc(3);
        chk("sda port0", 9'h000, {7'h00, scl, sda});
        wr_reg(ADDR_PORT, 8'h51);
        wr_reg(ADDR_DATA, 8'h7F);
        cyc(3);
        chk("sda shift", 9'h000, {7'h00, scl, sda});
        wr_reg(ADDR_DATA, 8'hFF);
        wr_reg(ADDR_CTRL, 8'h21);
        // Let both lines stand high before data falls, or no start is seen
        cyc(3);
        u_peer.set_lines(1'b1, 1'b0);
        cyc(6);
        rd_reg(ADDR_STATUS, 8'h80, "start flag", 8'hC0);
        chk("scl start hold", 9'h000, {7'h00, scl, sda});
        wr_reg(ADDR_STATUS, 8'h80);
        cyc(3);
        chk("scl start release", 9'h002, {7'h00, scl, sda});
        u_peer.set_lines(1'b1, 1'b1);
        wr_reg(ADDR_STATUS, 8'h0F);
        wr_reg(ADDR_CTRL, 8'h34);
        tick();
        cyc(3);
        chk("scl ovf hold", 9'h001, {7'h00, scl, sda});
        rd_reg(ADDR_STATUS, 8'h40, "ovf flag");
        wr_reg(ADDR_STATUS, 8'h40);
        cyc(3);
        chk("scl ovf release", 9'h003, {7'h00, scl, sda});
    endtask : t_two

    // ****************************************
    // Verdict and main sequence
    // ****************************************
    task automatic report_and_stop;
        if (miscompares == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (5) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_reset();
        t_soft();
        t_timer();
        t_ext();
        t_three();
        t_two();
        report_and_stop();
    end

    // Hang guard: running out counts as a mismatch
    initial
    begin
        #200000;
        miscompares++;
        report_and_stop();
    end
endmodule : serial_wire_mode_clock_select_tb_top

`default_nettype wire
